// [rtl/rmsl_strap_latch.sv]
// reset mode strap latch top
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - low data0 makes boot select byte wide
// - data1/data2 low: arbitration and space codes
// - data3..7 low add address lines cumulatively
// - data8/9 ports e,f; data11 test mode
// - clock strap picks synthesizer or crystal
// - low breakpoint strap enables background debug
// - other module pins come up as inputs
// - pulse outputs driven, receive and debug dedicated
// - register block base is m111
// - unused go external, reserved go neither internal nor external
// - some registers denied in user space
// - twelve chip selects, each may be port
// - bus pins serve bus or ports e,f
// - one 4k block at top of half
// - status shows data11 reset level
// - restrict bit limits to supervisor accesses
module rmsl_strap_latch
  import rmsl_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire logic                clockEnable,
  input  wire logic [STRAP_W-1:0]  dataStrap,
  input  wire logic                clockSourceStrap,
  input  wire logic                breakpointRequest,
  input  wire logic                moduleMapSelect,
  input  wire logic                supervisorRestrict,
  input  wire logic [23:0]         accessAddr,
  input  wire logic                accessValid,
  input  wire logic                accessSuper,
  input  wire logic [CS_COUNT-1:0] csPortMode,
  input  wire logic [CS_COUNT-1:0] csPortData,
  input  wire logic [CS_COUNT-1:0] csActive,
  output logic                     bootChipSelectByte,
  output logic                     busArbPins,
  output logic                     accessSpaceCodePins,
  output logic [ADDR_LINES-1:0]    addrLineEnable,
  output logic [CS_COUNT-1:0]      chipSelectEnable,
  output logic [CS_COUNT-1:0]      chipSelectOut,
  output logic                     portEPinsSel,
  output logic                     portFPinsSel,
  output logic                     testSlaveFlag,
  output logic                     synthOscSel,
  output logic                     backgroundDebugEn,
  output logic [7:0]               modulePinDir,
  output logic                     modulePinFuncEn,
  output logic                     pulseWidthOutEn,
  output logic                     dedicatedPinsKeep,
  output logic                     hitInternal,
  output logic                     goExternal,
  output logic                     accessDenied
);
  logic [STRAP_W-1:0] strapMeta;
  logic [STRAP_W-1:0] strapSync;
  logic [1:0]         modeMeta;
  logic [1:0]         modeSync;
  logic               mapMeta;
  logic               mapSync;
  logic               superMeta;
  logic               superSync;
  logic [STRAP_W-1:0] strap_reg;
  logic               clockSrc_reg;
  logic               debug_reg;
  rmsl_phase_e        phase_reg;
  rmsl_phase_e        phase_next;
  logic [ADDR_LINES-1:0] addrLines;
  logic [CS_COUNT-1:0]   csAllowed;

  rmsl_cfg_if cfgBus ();

  // a strap pulled low picks the alternate function
  function automatic logic strapPulled(input logic [STRAP_W-1:0] straps,
                                       input int                 pos);
    return ~straps[pos];
  endfunction

  // strap pin synchronisers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      strapMeta <= '0;
      strapSync <= '0;
      modeMeta  <= '0;
      modeSync  <= '0;
    end else if (clockEnable) begin
      strapMeta <= dataStrap;
      strapSync <= strapMeta;
      modeMeta  <= {clockSourceStrap, breakpointRequest};
      modeSync  <= modeMeta;
    end
  end

  // map and restrict bit synchronisers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mapMeta   <= 1'b0;
      mapSync   <= 1'b0;
      superMeta <= 1'b0;
      superSync <= 1'b0;
    end else if (clockEnable) begin
      mapMeta   <= moduleMapSelect;
      mapSync   <= mapMeta;
      superMeta <= supervisorRestrict;
      superSync <= superMeta;
    end
  end

  // phase: two edges fill the syncs, third captures
  always_comb begin
    unique case (phase_reg)
      RMSL_IN_RESET:  phase_next = RMSL_SYNC_WAIT;
      RMSL_SYNC_WAIT: phase_next = RMSL_CAPTURE;
      RMSL_CAPTURE:   phase_next = RMSL_RUN;
      RMSL_RUN:       phase_next = RMSL_RUN;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      phase_reg <= RMSL_IN_RESET;
    end else if (clockEnable) begin
      phase_reg <= phase_next;
    end
  end

  // data strap capture, frozen afterwards
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      strap_reg <= '1;
    end else if (clockEnable && phase_reg == RMSL_CAPTURE) begin
      strap_reg <= strapSync;
    end
  end

  // clock and breakpoint strap capture
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      clockSrc_reg <= 1'b1;
      debug_reg    <= 1'b0;
    end else if (clockEnable && phase_reg == RMSL_CAPTURE) begin
      clockSrc_reg <= modeSync[1];
      debug_reg    <= ~modeSync[0];
    end
  end

  // cumulative address line trade
  always_comb begin
    addrLines = '0;
    for (int i = 0; i < ADDR_LINES; i++) begin
      if (!strap_reg[ADDR_LO_BIT + i]) begin
        for (int j = 0; j <= i; j++) begin
          addrLines[j] = 1'b1;
        end
      end
    end
  end

  // chip select pins left after alternates
  always_comb begin
    csAllowed = '1;
    for (int k = 0; k < 3; k++) begin
      if (!strap_reg[ARB_BIT]) begin
        csAllowed[ARB_CS_LO + k] = 1'b0;
      end
      if (!strap_reg[FC_BIT]) begin
        csAllowed[FC_CS_LO + k] = 1'b0;
      end
    end
    for (int m = 0; m < ADDR_LINES; m++) begin
      if (addrLines[m]) begin
        csAllowed[CS_ADDR_BASE + m] = 1'b0;
      end
    end
  end

  // boot width and arbitration, space code trades
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bootChipSelectByte  <= 1'b0;
      busArbPins          <= 1'b0;
      accessSpaceCodePins <= 1'b0;
    end else if (clockEnable) begin
      bootChipSelectByte  <=
        strapPulled(strap_reg, BOOT_WIDE_BIT);
      busArbPins          <= strapPulled(strap_reg, ARB_BIT);
      accessSpaceCodePins <= strapPulled(strap_reg, FC_BIT);
    end
  end

  // address lines and chip selects left over
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      addrLineEnable   <= '0;
      chipSelectEnable <= CS_RESET;
    end else if (clockEnable) begin
      addrLineEnable   <= addrLines;
      chipSelectEnable <= csAllowed;
    end
  end

  // port e and f selection
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      portEPinsSel <= 1'b0;
      portFPinsSel <= 1'b0;
    end else if (clockEnable) begin
      portEPinsSel <=
        strapPulled(strap_reg, PORT_E_PINS_BIT);
      portFPinsSel <=
        strapPulled(strap_reg, PORT_F_PINS_BIT);
    end
  end

  // test slave status from data11
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      testSlaveFlag <= 1'b0;
    end else if (clockEnable) begin
      testSlaveFlag <=
        strapPulled(strap_reg, TEST_BIT);
    end
  end

  // clock source and background debug
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      synthOscSel       <= 1'b1;
      backgroundDebugEn <= 1'b0;
    end else if (clockEnable) begin
      synthOscSel       <= clockSrc_reg;
      backgroundDebugEn <= debug_reg;
    end
  end

  // chip select pins as output port, active low select
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      chipSelectOut <= CS_RESET;
    end else if (clockEnable) begin
      for (int n = 0; n < CS_COUNT; n++) begin
        if (csPortMode[n]) begin
          chipSelectOut[n] <= csPortData[n];
        end else begin
          chipSelectOut[n] <= ~csActive[n];
        end
      end
    end
  end

  // other module pins come up as plain inputs
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      modulePinDir    <= PORT_DIR_RESET;
      modulePinFuncEn <= 1'b0;
    end else if (clockEnable) begin
      modulePinDir    <= PORT_DIR_RESET;
      modulePinFuncEn <= 1'b0;
    end
  end

  // pulse outputs driven, dedicated pins kept
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pulseWidthOutEn   <= 1'b1;
      dedicatedPinsKeep <= 1'b1;
    end else if (clockEnable) begin
      pulseWidthOutEn   <= 1'b1;
      dedicatedPinsKeep <= 1'b1;
    end
  end

  // decoder hookup
  always_comb begin
    cfgBus.moduleMapSelect    = mapSync;
    cfgBus.supervisorRestrict = superSync;
    cfgBus.accessAddr         = accessAddr;
    cfgBus.accessValid        = accessValid;
    cfgBus.accessSuper        = accessSuper;
  end

  rmsl_addr_decode uDecode (
    .cfg (cfgBus.decode)
  );

  // registered decoder routing
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hitInternal <= 1'b0;
      goExternal  <= 1'b0;
    end else if (clockEnable) begin
      hitInternal <= cfgBus.hitInternal;
      goExternal  <= cfgBus.goExternal;
    end
  end

  // registered privilege refusal
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      accessDenied <= 1'b0;
    end else if (clockEnable) begin
      accessDenied <= cfgBus.denied;
    end
  end
endmodule
`default_nettype wire

// [rtl/rmsl_pkg.sv]
// constants and types for the reset mode strap latch
package rmsl_pkg;
  localparam int STRAP_W       = 12;
  localparam int CS_COUNT      = 12;
  localparam int BOOT_WIDE_BIT = 0;
  localparam int ARB_BIT       = 1;
  localparam int FC_BIT        = 2;
  localparam int ADDR_LO_BIT   = 3;
  localparam int ADDR_HI_BIT   = 7;
  localparam int PORT_E_PINS_BIT     = 8;
  localparam int PORT_F_PINS_BIT     = 9;
  localparam int TEST_BIT      = 11;
  localparam int ADDR_LINES    = 5;
  localparam int CS_ADDR_BASE  = 6;
  localparam int ARB_CS_LO     = 0;
  localparam int FC_CS_LO      = 3;
  localparam logic [2:0] REG_BLOCK_TAIL = 3'h7;
  localparam logic [11:0] REG_RESERVED_BASE = 12'hf00;
  localparam logic [11:0] REG_PRIV_BASE     = 12'ha00;
  localparam logic [11:0] REG_PRIV_LIMIT    = 12'ha7f;
  localparam logic [CS_COUNT-1:0] CS_RESET  = 12'hfff;
  localparam logic [7:0] PORT_DIR_RESET     = 8'h00;
  typedef enum logic [1:0] {
    RMSL_IN_RESET  = 2'b00,
    RMSL_SYNC_WAIT = 2'b01,
    RMSL_CAPTURE   = 2'b10,
    RMSL_RUN       = 2'b11
  } rmsl_phase_e;
endpackage

// [rtl/rmsl_cfg_if.sv]
// configuration carried from the latch to the address decoder
`timescale 1ns/10ps
`default_nettype none
interface rmsl_cfg_if;
  logic        moduleMapSelect;
  logic        supervisorRestrict;
  logic [23:0] accessAddr;
  logic        accessValid;
  logic        accessSuper;
  logic        hitInternal;
  logic        goExternal;
  logic        denied;
  modport latch (output moduleMapSelect, supervisorRestrict, accessAddr,
                 accessValid, accessSuper,
                 input hitInternal, goExternal, denied);
  modport decode (input moduleMapSelect, supervisorRestrict, accessAddr,
                  accessValid, accessSuper,
                  output hitInternal, goExternal, denied);
endinterface
`default_nettype wire

// [rtl/rmsl_addr_decode.sv]
// internal register block decoder
`timescale 1ns/10ps
`default_nettype none
module rmsl_addr_decode
  import rmsl_pkg::*;
(
  rmsl_cfg_if.decode cfg
);
  logic inBlock;
  logic reservedHit;
  logic privHit;
  // block base at upper nibble of m111
  always_comb begin
    inBlock = cfg.accessValid &&
              (cfg.accessAddr[23:12] ==
               {cfg.moduleMapSelect, REG_BLOCK_TAIL, 8'hff});
    reservedHit = cfg.accessAddr[11:0] >= REG_RESERVED_BASE;
    privHit = (cfg.accessAddr[11:0] >= REG_PRIV_BASE) &&
              (cfg.accessAddr[11:0] <= REG_PRIV_LIMIT);
  end
  // reserved goes neither internal nor out, unused goes out
  always_comb begin
    cfg.hitInternal = inBlock && !reservedHit && privHit;
    cfg.goExternal  = cfg.accessValid &&
                      (!inBlock || (!reservedHit && !privHit));
    cfg.denied = inBlock && privHit && cfg.supervisorRestrict &&
                 !cfg.accessSuper;
  end
endmodule
`default_nettype wire

// [tb/rmsl_strap_latch_asserts.sv]
// concurrent checks on the strap latch top ports
`timescale 1ns/10ps
`default_nettype none
module rmsl_strap_latch_asserts (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        clockEnable,
  input wire logic [11:0] dataStrap,
  input wire logic        moduleMapSelect,
  input wire logic        supervisorRestrict,
  input wire logic [23:0] accessAddr,
  input wire logic        accessValid,
  input wire logic        accessSuper,
  input wire logic        bootChipSelectByte,
  input wire logic        testSlaveFlag,
  input wire logic        hitInternal,
  input wire logic        goExternal,
  input wire logic        accessDenied
);
  logic [2:0] edgeCnt;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // enabled edges since reset release, saturating
  always_ff @(posedge clock or posedge reset) begin
    if (reset) edgeCnt <= 3'h0;
    else if (clockEnable && edgeCnt != 3'h7) edgeCnt <= edgeCnt + 3'h1;
  end
  sequence blockAccess;
    $stable({moduleMapSelect, supervisorRestrict}) [*3] ##0 (accessValid &&
      clockEnable && accessAddr[23:12] == {moduleMapSelect, 11'h7ff});
  endsequence
  boot_width_a: assert property (
    edgeCnt == 3'h4 |-> bootChipSelectByte == !dataStrap[0])
    else $error("boot width differs from strap");
  slave_flag_a: assert property (
    edgeCnt == 3'h4 |-> testSlaveFlag == !dataStrap[11])
    else $error("slave flag differs from strap");
  config_hold_a: assert property (
    edgeCnt == 3'h7 |-> $stable({bootChipSelectByte, testSlaveFlag}))
    else $error("configuration moved after capture");
  reg_hit_a: assert property (
    blockAccess ##0 accessAddr[11:7] == 5'h14 |=> hitInternal && !goExternal)
    else $error("register window missed");
  reserved_a: assert property (
    blockAccess ##0 accessAddr[11:8] == 4'hf |=> !hitInternal && !goExternal)
    else $error("reserved offset answered");
  unused_ext_a: assert property (
    blockAccess ##0 accessAddr[11:8] == 4'h3 |=> goExternal && !hitInternal)
    else $error("unused offset not sent out");
  user_deny_a: assert property (
    blockAccess ##0 (accessAddr[11:7] == 5'h14 && supervisorRestrict &&
      !accessSuper) |=> accessDenied)
    else $error("user access not denied");
  super_allow_a: assert property (
    blockAccess ##0 (accessAddr[11:7] == 5'h14 &&
      (accessSuper || !supervisorRestrict)) |=> !accessDenied)
    else $error("allowed access denied");
endmodule
bind rmsl_strap_latch rmsl_strap_latch_asserts u_chk (.*);
`default_nettype wire

// [tb/rmsl_board_model.sv]
// board straps: pull-ups, optional pull-downs, bus traffic later
`timescale 1ns/10ps
`default_nettype none
module rmsl_board_model (
  input  wire logic [11:0] pullLow,
  input  wire logic        clockPullLow,
  input  wire logic        breakPullLow,
  input  wire logic        busy,
  input  wire logic [11:0] busData,
  output logic      [11:0] dataStrap,
  output logic             clockSourceStrap,
  output logic             breakpointRequest
);
  // left pin floats high, pulled pin reads low
  assign dataStrap = busy ? busData : ~pullLow;
  assign clockSourceStrap = ~clockPullLow;
  assign breakpointRequest = ~breakPullLow;
endmodule
`default_nettype wire

// [tb/rmsl_strap_latch_tb_top.sv]
// self-checking bench for the reset mode strap latch
`timescale 1ns/10ps
`default_nettype none
module rmsl_strap_latch_tb_top;
  logic        clock, reset, clockEnable, busy, clockPullLow, breakPullLow;
  logic        moduleMapSelect, supervisorRestrict, accessValid, accessSuper;
  logic        clockSourceStrap, breakpointRequest, bootChipSelectByte;
  logic        busArbPins, accessSpaceCodePins, portEPinsSel, portFPinsSel;
  logic        testSlaveFlag, synthOscSel, backgroundDebugEn, modulePinFuncEn;
  logic        pulseWidthOutEn, dedicatedPinsKeep, hitInternal, goExternal;
  logic        accessDenied;
  logic [11:0] pullLow, busData, dataStrap, csPortMode, csPortData, csActive;
  logic [11:0] chipSelectOut, chipSelectEnable;
  logic [23:0] accessAddr;
  logic [4:0]  addrLineEnable;
  logic [7:0]  modulePinDir;
  int          err_count, comparisons, cycles;
  rmsl_board_model u_board (.*);
  rmsl_strap_latch u_dut (.*);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    if (++cycles == 1000) begin
      err_count++;
      test_done();
    end
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic strap_run(input logic [11:0] pl);
    logic [4:0] ae;
    logic [11:0] ce;
    ae = 5'h00;
    for (int j = 0; j < 5; j++)
      for (int k = j; k < 5; k++) ae[j] = ae[j] | pl[3+k];
    ce = {1'b1, ~ae, {3{~pl[2]}}, {3{~pl[1]}}};
    @(negedge clock);
    {pullLow, busData, busy, reset} = {pl, pl, 2'b01};
    {clockPullLow, breakPullLow} = {pl[0], pl[1]};
    repeat (5) @(negedge clock);
    reset = 1'b0;
    repeat (6) @(negedge clock);
    repeat (2) begin
      check(bootChipSelectByte, pl[0]);
      check({accessSpaceCodePins, busArbPins}, pl[2:1]);
      check(addrLineEnable, ae);
      check(chipSelectEnable, ce);
      check({portFPinsSel, portEPinsSel}, pl[9:8]);
      check(synthOscSel, !pl[0]);
      check(backgroundDebugEn, pl[1]);
      check({modulePinDir, modulePinFuncEn}, 9'h000);
      check({pulseWidthOutEn, dedicatedPinsKeep}, 2'h3);
      check(testSlaveFlag, pl[11]);
      busy = 1'b1;
      repeat (4) @(negedge clock) busData = ~busData;
    end
  endtask
  task automatic access(input logic [23:0] a, input logic s,
                        input logic [2:0] exp);
    {accessAddr, accessSuper, accessValid} = {a, s, 1'b1};
    @(negedge clock);
    check({hitInternal, goExternal, accessDenied}, exp);
  endtask
  initial begin
    {reset, clockEnable, busy, clockPullLow, breakPullLow} = 5'h18;
    {moduleMapSelect, supervisorRestrict, accessValid, accessSuper} = 4'h0;
    {accessAddr, pullLow, busData, csPortMode, csPortData, csActive} = 84'h0;
    strap_run(12'h000);
    for (int i = 0; i < 12; i++) strap_run(12'h001 << i);
    $display("strap tests done");
    for (int m = 0; m < 2; m++) begin
      {moduleMapSelect, supervisorRestrict} = {m[0], m[0]};
      repeat (3) @(negedge clock);
      access({m[0], 11'h7ff, 12'ha10}, 1'b0, {2'b10, m[0]});
      access({m[0], 11'h7ff, 12'ha7f}, 1'b1, 3'b100);
      access({m[0], 11'h7ff, 12'hf20}, 1'b0, 3'b000);
      access({m[0], 11'h7ff, 12'h300}, 1'b1, 3'b010);
      access({m[0], 11'h7ff, 12'ha00}, 1'b0, {2'b10, m[0]});
      access({~m[0], 11'h7ff, 12'ha00}, 1'b1, 3'b010);
      accessValid = 1'b0;
    end
    $display("access tests done");
    {csPortMode, csPortData, csActive} = {12'h0f0, 12'h0a5, 12'h00f};
    @(negedge clock);
    check(chipSelectOut, 12'hfa0);
    {clockEnable, csPortData} = {1'b0, 12'h050};
    @(negedge clock);
    check(chipSelectOut, 12'hfa0);
    clockEnable = 1'b1;
    @(negedge clock);
    check(chipSelectOut, 12'hf50);
    $display("chip select tests done");
    test_done();
  end
endmodule
`default_nettype wire
